// ===== rtl/wor_timer_ctrl.sv
// Wake-on-radio sleep timer control with Avalon-MM register port
//
// Function
// R1: Delay codes 4..7 give 16,24,32,48 periods
// R2: Calibrate slow oscillator after each first event only while enable set
// R3: Resolution codes give 1,32,1024,32768 periods/step
// R4: Software keeps resolution 0 or 1 when polling
// R5: Every resolution code accepted and applied
// R6: First event after value times resolution periods
// R7: Delay codes 0..3 give 4,6,8,12 periods
// R8: Clearing power-down starts initial calibration
// R9: Second-event count starts at first event, strobes, stops
`timescale 1ns/1ps
module wor_timer_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire wor_pkg::avmm_req_t avs_req,
  output wor_pkg::avmm_rsp_t avs_rsp,
  // Timer link to the rest of the unit
  output logic [15:0] first_event_timeout,
  output logic [1:0] wake_resolution_sel,
  output wor_pkg::wor_events_t events,
  // Interrupt
  output logic irq
);
  import wor_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] evt0;
    logic [7:0] ctrl;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [15:0] pre;
    logic [15:0] steps;
    logic [3:0] cal_cnt;
    logic cal_busy;
    logic evt0_strobe;
    logic ack;
    logic [31:0] rdata;
  } ctrl_state_t;

  ctrl_state_t s_q, s_d;

  logic slow_tick;
  logic evt1_strobe;
  logic evt1_busy;
  logic running;
  logic [15:0] pre_limit;
  logic [15:0] step_limit;
  logic req;
  logic wr_now;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] w1c;
  logic [7:0] ctrl_wr;
  logic start_cal;
  logic fire0;

  // ------------------------------------------------------------------
  // Slow oscillator period source
  // ------------------------------------------------------------------
  osc_divider u_div (
    .core_clk(core_clk),
    .rst(rst),
    .run(running),
    .slow_tick(slow_tick)
  );

  // ------------------------------------------------------------------
  // Second event
  // ------------------------------------------------------------------
  event_delay u_dly (
    .core_clk(core_clk),
    .rst(rst),
    .slow_tick(slow_tick),
    .start(s_q.evt0_strobe), // [R9]
    .delay_code(s_q.ctrl[CTRL_EVT1_LSB +: 3]),
    .strobe(evt1_strobe),
    .busy(evt1_busy)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    running = ~s_q.ctrl[CTRL_PD_BIT];
    // No clamp on the selector: all four codes scale the step
    pre_limit = decode_resolution(s_q.ctrl[CTRL_RES_LSB +: 2]); // [R3] [R5]
    step_limit = (s_q.evt0 == 16'h0000) ? 16'h0000 : s_q.evt0 - 16'h0001;
    req = avs_req.read | avs_req.write;
    wr_now = avs_req.write & s_q.ack;
    fire0 = 1'b0;
    start_cal = 1'b0;
    w1c = '0;
    ctrl_wr = s_q.ctrl;

    // Bus handshake: one wait cycle, then complete
    s_d.ack = req & ~s_q.ack;
    if (req && !s_q.ack)
    begin
      s_d.rdata = 32'h0000_0000;
      if (reg_hit(avs_req.address, IDX_EVT_HI))
      begin
        s_d.rdata = {24'h000000, s_q.evt0[15:8]};
      end
      else if (reg_hit(avs_req.address, IDX_EVT_LO))
      begin
        s_d.rdata = {24'h000000, s_q.evt0[7:0]};
      end
      else if (reg_hit(avs_req.address, IDX_CTRL))
      begin
        s_d.rdata = {24'h000000, s_q.ctrl & CTRL_WMASK};
      end
      else if (reg_hit(avs_req.address, IDX_STATUS))
      begin
        s_d.rdata = {29'h00000000, s_q.status};
      end
      else if (reg_hit(avs_req.address, IDX_MASK))
      begin
        s_d.rdata = {29'h00000000, s_q.mask};
      end
      else if (reg_hit(avs_req.address, IDX_STATE))
      begin
        s_d.rdata = {29'h00000000, s_q.cal_busy, evt1_busy, running};
      end
    end

    // Register writes at the completing edge
    if (wr_now && avs_req.byteenable[0])
    begin
      if (reg_hit(avs_req.address, IDX_EVT_HI))
      begin
        s_d.evt0[15:8] = avs_req.writedata[7:0];
      end
      if (reg_hit(avs_req.address, IDX_EVT_LO))
      begin
        s_d.evt0[7:0] = avs_req.writedata[7:0];
      end
      if (reg_hit(avs_req.address, IDX_CTRL))
      begin
        ctrl_wr = avs_req.writedata[7:0] & CTRL_WMASK;
        s_d.ctrl = ctrl_wr;
        if (s_q.ctrl[CTRL_PD_BIT] && !ctrl_wr[CTRL_PD_BIT])
        begin
          start_cal = 1'b1; // [R8]
        end
      end
      if (reg_hit(avs_req.address, IDX_STATUS))
      begin
        w1c = avs_req.writedata[ST_W-1:0];
      end
      if (reg_hit(avs_req.address, IDX_MASK))
      begin
        s_d.mask = avs_req.writedata[ST_W-1:0];
      end
    end

    // First event: prescaler of resolution periods, then step count
    s_d.evt0_strobe = 1'b0;
    if (!running)
    begin
      s_d.pre = 16'h0000;
      s_d.steps = 16'h0000;
    end
    else if (slow_tick)
    begin
      if (s_q.pre >= pre_limit - 16'h0001)
      begin
        s_d.pre = 16'h0000;
        if (s_q.steps >= step_limit)
        begin
          s_d.steps = 16'h0000;
          fire0 = 1'b1; // [R6]
        end
        else
        begin
          s_d.steps = s_q.steps + 16'h0001;
        end
      end
      else
      begin
        s_d.pre = s_q.pre + 16'h0001;
      end
    end
    s_d.evt0_strobe = fire0;

    // Calibration: initial one always, periodic only when enabled
    if (fire0 && s_q.ctrl[CTRL_CAL_BIT])
    begin
      start_cal = 1'b1; // [R2]
    end
    ev = '0;
    if (start_cal)
    begin
      s_d.cal_busy = 1'b1;
      s_d.cal_cnt = 4'h0;
    end
    else if (!running)
    begin
      s_d.cal_busy = 1'b0;
      s_d.cal_cnt = 4'h0;
    end
    else if (s_q.cal_busy && slow_tick)
    begin
      if (s_q.cal_cnt + 4'h1 >= CAL_SLOW_TICKS)
      begin
        s_d.cal_busy = 1'b0;
        ev[ST_CAL] = 1'b1;
      end
      else
      begin
        s_d.cal_cnt = s_q.cal_cnt + 4'h1;
      end
    end

    // Sticky status, set wins over write-one-to-clear
    ev[ST_EVT0] = s_q.evt0_strobe;
    ev[ST_EVT1] = evt1_strobe;
    for (int i = 0; i < ST_W; i++)
    begin
      s_d.status[i] = ev[i] | (s_q.status[i] & ~w1c[i]);
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.evt0 <= EVT0_RST;
      s_q.ctrl <= CTRL_RST; // [R2] [R3]
      s_q.status <= ST_RST;
      s_q.mask <= ST_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign avs_rsp.waitrequest = req & ~s_q.ack;
  assign avs_rsp.readdata = s_q.rdata;
  assign first_event_timeout = s_q.evt0;
  assign wake_resolution_sel = s_q.ctrl[CTRL_RES_LSB +: 2];
  assign events.first_event_timeout_strobe = s_q.evt0_strobe;
  assign events.second_event_delay_strobe = evt1_strobe;
  assign events.calib_active = s_q.cal_busy;
  assign events.slow_osc_enable = ~s_q.ctrl[CTRL_PD_BIT];
  assign irq = |(s_q.status & s_q.mask);
endmodule

// ===== shared/wor_pkg.sv
// Constants, types and decode functions for the wake-on-radio timer control
package wor_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0] IDX_EVT_HI = 6'h1E;
  localparam logic [5:0] IDX_EVT_LO = 6'h1F;
  localparam logic [5:0] IDX_CTRL = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  localparam logic [5:0] IDX_MASK = 6'h31;
  localparam logic [5:0] IDX_STATE = 6'h32;

  // ------------------------------------------------------------------
  // Control register layout and values after reset
  // ------------------------------------------------------------------
  localparam int CTRL_PD_BIT = 7;
  localparam int CTRL_EVT1_LSB = 4;
  localparam int CTRL_CAL_BIT = 3;
  localparam int CTRL_RES_LSB = 0;
  localparam logic [7:0] CTRL_RST = 8'hF8;
  localparam logic [7:0] CTRL_WMASK = 8'hFB;
  localparam logic [15:0] EVT0_RST = 16'h876B;

  // ------------------------------------------------------------------
  // Status and mask layout
  // ------------------------------------------------------------------
  localparam int ST_W = 3;
  localparam int ST_EVT0 = 0;
  localparam int ST_EVT1 = 1;
  localparam int ST_CAL = 2;
  localparam logic [ST_W-1:0] ST_RST = 3'h0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int XOSC_PER_SLOW = 750;
  localparam int CORE_PER_XOSC = 1;
  localparam logic [9:0] SLOW_DIV_CYCLES = 10'(XOSC_PER_SLOW * CORE_PER_XOSC);
  localparam logic [3:0] CAL_SLOW_TICKS = 4'h4;

  // ------------------------------------------------------------------
  // Bus carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  typedef struct packed {
    logic first_event_timeout_strobe;
    logic second_event_delay_strobe;
    logic calib_active;
    logic slow_osc_enable;
  } wor_events_t;

  // ------------------------------------------------------------------
  // Decoders
  // ------------------------------------------------------------------
  function automatic logic [5:0] decode_second_event_delay(input logic [2:0] code);
    logic [5:0] t;
    t = 6'h04;
    case (code)
      3'h0: t = 6'h04;
      3'h1: t = 6'h06;
      3'h2: t = 6'h08;
      3'h3: t = 6'h0C;
      3'h4: t = 6'h10;
      3'h5: t = 6'h18;
      3'h6: t = 6'h20;
      3'h7: t = 6'h30;
      default: t = 6'h04;
    endcase
    return t;
  endfunction

  function automatic logic [15:0] decode_resolution(input logic [1:0] code);
    logic [15:0] t;
    t = 16'h0001;
    case (code)
      2'h0: t = 16'h0001;
      2'h1: t = 16'h0020;
      2'h2: t = 16'h0400;
      2'h3: t = 16'h8000;
      default: t = 16'h0001;
    endcase
    return t;
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    return (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

endpackage

// ===== rtl/osc_divider.sv
// Slow oscillator period tick derived from the core clock
`timescale 1ns/1ps
module osc_divider (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  // Tick out
  output logic slow_tick
);
  import wor_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run)
    begin
      s_d.cnt = 10'h000;
    end
    else if (s_q.cnt == SLOW_DIV_CYCLES - 10'h001)
    begin
      s_d.cnt = 10'h000;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 10'h001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign slow_tick = s_q.tick;
endmodule

// ===== rtl/event_delay.sv
// Second-event delay counter started by the first event
`timescale 1ns/1ps
module event_delay (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Timing inputs
  input wire logic slow_tick,
  input wire logic start,
  input wire logic [2:0] delay_code,
  // Results
  output logic strobe,
  output logic busy
);
  import wor_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic busy;
    logic strobe;
  } dly_state_t;

  dly_state_t s_q, s_d;
  logic [5:0] target;

  always_comb
  begin
    target = decode_second_event_delay(delay_code); // [R1] [R7]
    s_d = s_q;
    s_d.strobe = 1'b0;
    if (start)
    begin
      s_d.busy = 1'b1; // [R9]
      s_d.cnt = 6'h00;
    end
    else if (s_q.busy && slow_tick)
    begin
      if (s_q.cnt + 6'h01 >= target)
      begin
        s_d.busy = 1'b0; // [R9]
        s_d.strobe = 1'b1;
        s_d.cnt = 6'h00;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign strobe = s_q.strobe;
  assign busy = s_q.busy;
endmodule

// ===== bench/wor_timer_ctrl_assertions.sv
// Port checks for the wake timer control
`timescale 1ns/1ps
module wor_timer_ctrl_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Observed ports
  input wire wor_pkg::avmm_req_t avs_req,
  input wire wor_pkg::avmm_rsp_t avs_rsp,
  input wire logic [15:0] first_event_timeout,
  input wire logic [1:0] wake_resolution_sel,
  input wire wor_pkg::wor_events_t events,
  input wire logic irq
);
  import wor_pkg::*;
  logic req;
  logic done;
  logic [2:0] mask_q;
  logic [15:0] gap_q;
  assign req = avs_req.read | avs_req.write;
  assign done = avs_req.write & ~avs_rsp.waitrequest & avs_req.byteenable[0];
  // Mask copy and cycles since first event
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mask_q <= 3'h0;
      gap_q <= 16'h0;
    end
    else
    begin
      if (done && avs_req.address == 8'hC4)
        mask_q <= avs_req.writedata[2:0];
      gap_q <= events.first_event_timeout_strobe ? 16'h1 : gap_q + 16'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_ctrl_wr;
    done && avs_req.address == 8'h80;
  endsequence
  sequence s_lo_wr;
    done && avs_req.address == 8'h7C;
  endsequence
  chk_wait_first: assert property (req && !$past(req) |-> avs_rsp.waitrequest)
    else $error("no wait cycle on new request");
  chk_wait_once: assert property (req && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
    else $error("more than one wait cycle");
  chk_idle_nowait: assert property (!req |-> !avs_rsp.waitrequest)
    else $error("wait while idle");
  chk_ev0_pulse: assert property (events.first_event_timeout_strobe |=> !events.first_event_timeout_strobe)
    else $error("first event strobe too long");
  chk_ev1_pulse: assert property (events.second_event_delay_strobe |=> !events.second_event_delay_strobe)
    else $error("second event strobe too long");
  chk_ev1_gap: assert property (events.second_event_delay_strobe |->
    gap_q >= 16'h0BAE && gap_q <= 16'h8CAA)
    else $error("second event delay out of range");
  chk_pd_quiet: assert property (!events.slow_osc_enable |->
    !(events.first_event_timeout_strobe | events.second_event_delay_strobe | events.calib_active))
    else $error("activity while powered down");
  chk_ctrl_apply: assert property (s_ctrl_wr |=>
    wake_resolution_sel == $past(avs_req.writedata[1:0]) &&
    events.slow_osc_enable == !$past(avs_req.writedata[7]))
    else $error("control write not applied");
  chk_lo_apply: assert property (s_lo_wr |=>
    first_event_timeout[7:0] == $past(avs_req.writedata[7:0]))
    else $error("timeout low byte not applied");
  chk_cal_start: assert property (s_ctrl_wr ##0
    (!avs_req.writedata[7] && !events.slow_osc_enable) |=> events.calib_active)
    else $error("no calibration on power up");
  chk_irq_masked: assert property (mask_q == 3'h0 |-> !irq)
    else $error("interrupt while fully masked");
endmodule
bind wor_timer_ctrl wor_timer_ctrl_assertions u_chk (.core_clk(core_clk), .rst(rst),
  .avs_req(avs_req), .avs_rsp(avs_rsp), .first_event_timeout(first_event_timeout),
  .wake_resolution_sel(wake_resolution_sel), .events(events), .irq(irq));

// ===== bench/test_wor_timer_ctrl.sv
// Self-checking bench for the wake timer control
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_wor_timer_ctrl;
  import wor_pkg::*;
  logic core_clk;
  logic rst;
  avmm_req_t req;
  avmm_rsp_t rsp;
  logic [15:0] fet;
  logic [1:0] res;
  wor_events_t ev;
  logic irq;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int c1 = 0;
  int t0 = 0;
  int x;
  logic [7:0] r8;
  logic [7:0] rd_q[$];
  int e0_q[$];
  int e1_q[$];
  wor_timer_ctrl i_dut (.core_clk(core_clk), .rst(rst), .avs_req(req), .avs_rsp(rsp),
    .first_event_timeout(fet), .wake_resolution_sel(res), .events(ev), .irq(irq));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------------
  // Result watcher
  // ------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    c1 <= ev.first_event_timeout_strobe ? 1 : c1 + 1;
    if (req.read && rsp.waitrequest === 1'b0 && rd_q.size() > 0)
    begin
      r8 = rd_q.pop_front();
      `CHK("readdata", {24'h0, r8}, rsp.readdata)
    end
    if (ev.first_event_timeout_strobe === 1'b1 && e0_q.size() > 0)
    begin
      x = e0_q.pop_front();
      `CHK("first event", x, (cyc - t0 + 375) / 750)
    end
    if (ev.second_event_delay_strobe === 1'b1 && e1_q.size() > 0)
    begin
      x = e1_q.pop_front();
      `CHK("second event", x, (c1 + 375) / 750)
    end
  end
  // ------------------------------------------------------------------
  // Bus and wait tasks
  // ------------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: {24'h0, d}};
    // Hold until waitrequest is sampled low at a rising edge, release there
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      fail_count++;
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_ev(input int k);
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (!(k == 0 ? ev.first_event_timeout_strobe === 1'b1 : k == 1 ? ev.second_event_delay_strobe === 1'b1 :
      ev.calib_active === 1'b0) && n < 60000);
    if (n >= 60000)
      fail_count++;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial
  begin
    req = '0;
    rst = 1'b1;
    x = $urandom(32'h71F5);
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK("timeout", 16'h876B, fet)
    `CHK("resolution", 2'h0, res)
    rd(8'h80, 8'hF8);
    rd(8'h84, 8'h00);
    rd(8'h81, 8'h00);
    bus(1'b1, 8'h80, 8'hFF);
    rd(8'h80, 8'hFB);
    $display("reset test done");
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, 8'h80, 8'hF8 | 8'(c));
      @(negedge core_clk);
      `CHK("resolution", 2'(c), res)
    end
    r8 = 8'($urandom);
    bus(1'b1, 8'h7C, r8);
    @(negedge core_clk);
    `CHK("timeout low", r8, fet[7:0])
    $display("resolution test done");
    bus(1'b1, 8'h78, 8'h00);
    bus(1'b1, 8'h7C, 8'h11);
    bus(1'b1, 8'hC4, 8'h07);
    e0_q.push_back(17);
    e1_q.push_back(4);
    bus(1'b1, 8'h80, 8'h08);
    t0 = cyc;
    repeat (2) @(negedge core_clk);
    `CHK("calibrating", 1'b1, ev.calib_active)
    wait_ev(1);
    @(negedge core_clk);
    `CHK("irq", 1'b1, irq)
    wait_ev(2);
    rd(8'hC0, 8'h07);
    bus(1'b1, 8'hC4, 8'h00);
    @(negedge core_clk);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, 8'hC4, 8'h07);
    bus(1'b1, 8'hC0, 8'h07);
    rd(8'hC0, 8'h00);
    @(negedge core_clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("event test done");
    e1_q.push_back(16);
    bus(1'b1, 8'h80, 8'h40);
    wait_ev(0);
    repeat (2) @(negedge core_clk);
    `CHK("no calibration", 1'b0, ev.calib_active)
    wait_ev(1);
    $display("long delay test done");
    bus(1'b1, 8'h80, 8'h81);
    @(negedge core_clk);
    `CHK("osc off", 1'b0, ev.slow_osc_enable)
    bus(1'b1, 8'h7C, 8'h01);
    e0_q.push_back(32);
    bus(1'b1, 8'h80, 8'h01);
    t0 = cyc;
    wait_ev(0);
    @(negedge core_clk);
    $display("scaled timeout test done");
    final_report();
  end
endmodule
